// ---- dv/cwpm_bus_model.sv ----
`timescale 1ns/1ps
module cwpm_bus_model (
  input  wire logic clock,
  input  wire logic drive_dominant,
  output logic      bus_state
);
  logic remote = 1'b1;
  // wired-and bus: any dominant driver wins over the remote node
  assign bus_state = remote & ~drive_dominant;
  // remote node holds a level for n cycles, changing at falling edges
  task automatic hold(input logic lvl, input int n);
    remote = lvl;
    repeat (n) @(negedge clock);
  endtask : hold
endmodule : cwpm_bus_model

// ---- dv/cwpm_checker.sv ----
`timescale 1ns/1ps
module cwpm_checker #(
  parameter int unsigned FILTER_CYC = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic standby_select,
  input wire logic normal_select_n,
  input wire logic txd,
  input wire logic bus_state,
  input wire logic rxd,
  input wire logic drive_dominant,
  input wire logic main_rx_enable,
  input wire logic wake_pattern_seen,
  input wire logic standby_mode
);
  logic [15:0] dom_run;
  // dominant run length, saturates so long stuck buses never wrap
  always_ff @(posedge clock)
    dom_run <= bus_state ? 16'h0 : dom_run + {15'h0, ~&dom_run};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_reset_state: assert property (disable iff (1'b0) rst |=> rxd &&
    !drive_dominant && !main_rx_enable && !wake_pattern_seen && standby_mode)
    else $error("reset state wrong");
  chk_rx_idle_high: assert property (
    standby_mode && $past(standby_mode, 4) && !wake_pattern_seen |-> rxd)
    else $error("rxd low before wake");
  chk_drive_follow: assert property (
    !standby_select |=> drive_dominant == !$past(txd))
    else $error("driver not following txd");
  chk_rx_mirror: assert property (
    !standby_select |=> main_rx_enable && !standby_mode
      && rxd == $past(bus_state))
    else $error("rxd not mirroring bus");
  chk_standby_quiet: assert property (
    standby_select |=> !drive_dominant && !main_rx_enable && standby_mode)
    else $error("driver or receiver active in standby");
  // run length read two samples back, at the filter hit itself
  chk_wake_filtered: assert property (
    $rose(wake_pattern_seen) |-> $past(dom_run, 2) > FILTER_CYC)
    else $error("wake on unfiltered dominant");
  chk_fall_filtered: assert property (
    $fell(rxd) && standby_mode && $past(standby_mode, 2)
      |-> $past(dom_run, 2) > FILTER_CYC)
    else $error("rxd fell without filtered dominant");
  chk_seen_hold: assert property (
    wake_pattern_seen && standby_select |=> wake_pattern_seen)
    else $error("wake indication dropped in standby");
  chk_entry_clear: assert property (
    $rose(standby_mode) |-> !wake_pattern_seen)
    else $error("wake indication kept on standby entry");
endmodule : cwpm_checker
bind cwpm_channel cwpm_checker #(.FILTER_CYC(FILTER_CYC)) u_chk (
  .clock(clock), .rst(rst), .standby_select(standby_select),
  .normal_select_n(normal_select_n), .txd(txd), .bus_state(bus_state),
  .rxd(rxd), .drive_dominant(drive_dominant),
  .main_rx_enable(main_rx_enable), .wake_pattern_seen(wake_pattern_seen),
  .standby_mode(standby_mode));

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  localparam int F = 4;
  logic clock = 1'b0, rst = 1'b1, sb = 1'b1, txd = 1'b1;
  logic rxd, drv, mrx, seen, sbm, bus, rxd_l, sbm_l;
  int   err_count = 0, checks = 0, cyc = 0, low = 0;
  int   q[$];
  always #12.5 clock = ~clock;
  cwpm_channel #(.FILTER_CYC(F), .TIMEOUT_CYC(200)) dut (
    .clock(clock), .rst(rst), .standby_select(sb),
    .normal_select_n(~sb), .txd(txd), .bus_state(bus), .rxd(rxd),
    .drive_dominant(drv), .main_rx_enable(mrx),
    .wake_pattern_seen(seen), .standby_mode(sbm));
  cwpm_bus_model m (.clock(clock), .drive_dominant(drv), .bus_state(bus));
  // low-active select variant, fed the same mode in inverted form
  cwpm_channel #(.FILTER_CYC(F), .TIMEOUT_CYC(200), .SEL_LOW_VAR(1'b1))
    dut_low (
    .clock(clock), .rst(rst), .standby_select(sb),
    .normal_select_n(~sb), .txd(txd), .bus_state(bus), .rxd(rxd_l),
    .drive_dominant(), .main_rx_enable(), .wake_pattern_seen(),
    .standby_mode(sbm_l));
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", n, e, s);
    end
  endtask : cmp
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // alternating glitches, each no longer than the filter
  task automatic noise(int k);
    for (int i = 0; i < k; i++) begin
      txd = 1'($urandom); // ignored in standby
      m.hold(i[0], 1 + $urandom % F);
    end
  endtask : noise
  // rxd low from two cycles past the filter hit to one past bus release
  function automatic int low_len(int c);
    return (c > F + 1) ? c - F - 1 : 1;
  endfunction : low_len
  // three phases; a note holds the expected rxd low length
  task automatic wake_seq(int a, int b, int c);
    if (a > 0) m.hold(1'b0, a);
    if (b > 0) m.hold(1'b1, b);
    q.push_back(low_len(c));
    m.hold(1'b0, c);
    m.hold(1'b1, 12);
  endtask : wake_seq
  // hang guard, well above the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim;
    end
  end
  // each standby low pulse on rxd is matched to the oldest note
  always @(negedge clock) begin
    cmp("low variant mode", sbm, sbm_l);
    cmp("low variant rxd", rxd, rxd_l);
    if (sbm === 1'b1 && rxd === 1'b0) low++;
    else if (low > 0) begin
      cmp("pulse expected", 1, int'(q.size() > 0));
      if (q.size() > 0) cmp("low length", q.pop_front(), low);
      low = 0;
    end
  end
  initial begin
    void'($urandom(32'h2CF9B6E8));
    repeat (10) @(negedge clock);
    rst = 1'b0;
    noise(40);
    m.hold(1'b0, 60);
    m.hold(1'b1, 250);
    wake_seq(12, 12, 12);
    cmp("wake seen", 1, seen);
    q.push_back(low_len(10));
    m.hold(1'b0, 10);
    m.hold(1'b1, 10);
    m.hold(1'b0, F);
    m.hold(1'b1, 10);
    sb = 1'b0;
    for (int i = 0; i < 60; i++) begin
      txd = 1'($urandom);
      m.hold(1'($urandom), 1);
    end
    txd = 1'b1;
    sb = 1'b1;
    m.hold(1'b1, 10);
    m.hold(1'b0, 12);
    noise(6);
    m.hold(1'b1, 12);
    noise(6);
    wake_seq(0, 0, F + 1);
    sb = 1'b0;
    m.hold(1'b1, 5);
    sb = 1'b1;
    m.hold(1'b1, 10);
    cmp("wake cleared", 0, seen);
    m.hold(1'b0, 12);
    m.hold(1'b1, 250);
    wake_seq(12, 12, 12);
    repeat (10) @(negedge clock);
    cmp("notes pending", 0, q.size());
    end_sim;
  end
endmodule : tb

// ---- rtl/cwpm_channel.sv ----
`timescale 1ns/1ps
// What this block does
// - wake needs dominant, recessive, dominant, all filtered
// - after first dominant, wait recessive, ignore glitches
// - after recessive, wait dominant, ignore glitches
// - second dominant wakes; then every filtered dominant pulls low
// - wake shown as falling edge, low until one cycle past the dominant's end
// - filtered means held longer than filter time
// - shorter than minimum filter never counts
// - between filter limits may or may not count
// - longer than maximum filter always counts
// - filter passes 1 us or one 1 Mbps bit
// - pattern must finish within timeout, else reset
// - noise or stuck dominant never wakes
// - receive output high in standby until wake
// - standby chosen by level; two inverted pin variants
// - normal mode drives dominant on low transmit
// - standby ignores transmit, driver off, monitor only
module cwpm_channel
  import cwpm_pkg::*;
#(
  parameter int unsigned FILTER_CYC  = WAKE_FILTER_CYC,
  parameter int unsigned TIMEOUT_CYC = WAKE_TIMEOUT_CYC,
  parameter int unsigned FIFO_DEPTH  = EVT_FIFO_DEPTH,
  parameter bit          SEL_LOW_VAR = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic standby_select,
  input  wire logic normal_select_n,
  input  wire logic txd,
  input  wire logic bus_state,
  output logic      rxd,
  output logic      drive_dominant,
  output logic      main_rx_enable,
  output logic      wake_pattern_seen,
  output logic      standby_mode
);
  localparam int unsigned FW = $clog2(FILTER_CYC + 2);
  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 2);

  logic          standby_req;
  logic          stby;
  logic          next_stby;
  logic          entering;
  logic          last_bus;
  logic [FW-1:0] run_cnt;
  logic [FW-1:0] next_run_cnt;
  logic          filt_dom;
  logic          filt_rec;
  logic          qual;
  logic          next_qual;
  cwpm_state_t   state;
  cwpm_state_t   next_state;
  logic [TW-1:0] tmo_cnt;
  logic [TW-1:0] next_tmo_cnt;
  cwpm_evt_t     evt_in;
  cwpm_evt_t     evt_out;
  logic          evt_valid;
  logic          evt_ready;
  logic          evt_out_valid;
  logic          next_rxd;
  logic          next_drive;
  logic          next_mrx;
  logic          next_seen;

  // pin variant selects polarity of the mode level
  assign standby_req = SEL_LOW_VAR ? ~normal_select_n : standby_select;
  assign next_stby   = standby_req;
  assign entering    = standby_req & ~stby;

  // run length of the present bus level; saturates past the filter
  always_comb begin
    next_run_cnt = run_cnt;
    if (bus_state != last_bus || !stby) begin
      next_run_cnt = '0;
    end else if (32'(run_cnt) <= FILTER_CYC) begin
      next_run_cnt = run_cnt + 1'b1;
    end
  end

  // one pulse when a level has lasted longer than the filter time
  assign filt_dom = stby && 32'(run_cnt) == FILTER_CYC
                    && last_bus == LVL_DOM;
  assign filt_rec = stby && 32'(run_cnt) == FILTER_CYC
                    && last_bus == LVL_REC;
  // a qualified dominant lasts while the bus stays dominant
  assign next_qual = entering ? 1'b0 :
                     filt_dom ? 1'b1 :
                     (bus_state != LVL_DOM) ? 1'b0 : qual;

  // pattern monitor; short pulses never reach it
  always_comb begin
    next_state   = state;
    next_tmo_cnt = tmo_cnt;
    if (!stby || entering) begin
      next_state   = CWPM_IDLE;
      next_tmo_cnt = '0;
    end else begin
      case (state)
        CWPM_IDLE: begin
          if (filt_dom) begin
            next_state   = CWPM_WAIT_REC;
            next_tmo_cnt = '0;
          end
        end
        CWPM_WAIT_REC: begin
          next_tmo_cnt = tmo_cnt + 1'b1;
          if (32'(tmo_cnt) >= TIMEOUT_CYC) begin
            next_state = CWPM_IDLE;
          end else if (filt_rec) begin
            next_state = CWPM_WAIT_DOM;
          end
        end
        CWPM_WAIT_DOM: begin
          next_tmo_cnt = tmo_cnt + 1'b1;
          if (32'(tmo_cnt) >= TIMEOUT_CYC) begin
            next_state = CWPM_IDLE;
          end else if (filt_dom) begin
            next_state = CWPM_WOKEN;
          end
        end
        CWPM_WOKEN: begin
          next_tmo_cnt = '0;
        end
        default: begin
          next_state = CWPM_IDLE;
        end
      endcase
    end
  end

  // wake events queued so rxd replays each dominant in order
  assign evt_in.dom_start = filt_dom
    && (state == CWPM_WOKEN || (state == CWPM_WAIT_DOM
        && 32'(tmo_cnt) < TIMEOUT_CYC));
  assign evt_in.dom_end   = qual && bus_state != LVL_DOM
                            && state == CWPM_WOKEN;
  assign evt_valid = stby && !entering
                     && (evt_in.dom_start || evt_in.dom_end);
  assign evt_ready = 1'b1;

  cwpm_fifo #(
    .WIDTH (EVT_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_evt_fifo (
    .clock     (clock),
    .rst       (rst | entering),
    .in_data   (evt_in),
    .in_valid  (evt_valid),
    .in_ready  (),
    .out_data  (evt_out),
    .out_valid (evt_out_valid),
    .out_ready (evt_ready)
  );

  // output pins by mode
  always_comb begin
    next_drive = 1'b0;
    next_mrx   = 1'b0;
    next_rxd   = rxd;
    next_seen  = (state == CWPM_WOKEN);
    if (!standby_req) begin
      next_drive = ~txd;
      next_mrx   = 1'b1;
      next_rxd   = bus_state;
    end else if (entering) begin
      next_rxd  = 1'b1;
      next_seen = 1'b0;
    end else if (evt_out_valid) begin
      if (evt_out.dom_start) begin
        next_rxd = 1'b0;
      end else if (evt_out.dom_end) begin
        next_rxd = 1'b1;
      end
    end
  end

  // registers; standby after reset, as an undriven select pin would be
  always_ff @(posedge clock) begin
    if (rst) begin
      stby              <= 1'b1;
      last_bus          <= LVL_REC;
      run_cnt           <= '0;
      qual              <= 1'b0;
      state             <= CWPM_IDLE;
      tmo_cnt           <= '0;
      rxd               <= 1'b1;
      drive_dominant    <= 1'b0;
      main_rx_enable    <= 1'b0;
      wake_pattern_seen <= 1'b0;
      standby_mode      <= 1'b1;
    end else begin
      stby              <= next_stby;
      last_bus          <= bus_state;
      run_cnt           <= next_run_cnt;
      qual              <= next_qual;
      state             <= next_state;
      tmo_cnt           <= next_tmo_cnt;
      rxd               <= next_rxd;
      drive_dominant    <= next_drive;
      main_rx_enable    <= next_mrx;
      wake_pattern_seen <= next_seen;
      standby_mode      <= next_stby;
    end
  end
endmodule : cwpm_channel

// ---- rtl/cwpm_fifo.sv ----
`timescale 1ns/1ps
module cwpm_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // full at DEPTH entries; a pop in the same cycle is not counted on
  assign in_ready  = (32'(count) < DEPTH);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer wrap works for any depth, not only powers of two
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (32'(wr_ptr) == DEPTH - 1) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (32'(rd_ptr) == DEPTH - 1) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage has no reset, only written when pushed
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : cwpm_fifo

// ---- rtl/cwpm_pkg.sv ----
package cwpm_pkg;
  // clock rate of the implementation
  localparam int unsigned CLK_HZ            = 40_000_000;
  // wake filter time in ns, chosen below 1 bit at 1 Mbps so that bit passes
  localparam int unsigned WAKE_FILTER_NS    = 900;
  localparam int unsigned WAKE_FILTER_CYC   =
    (WAKE_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // wake timeout in us, longest time so rounded down
  localparam int unsigned WAKE_TIMEOUT_US   = 1000;
  localparam int unsigned WAKE_TIMEOUT_CYC  =
    WAKE_TIMEOUT_US * (CLK_HZ / 1_000_000);
  // wake event fifo
  localparam int unsigned EVT_FIFO_DEPTH    = 4;
  localparam int unsigned EVT_FIFO_WIDTH    = 2;
  localparam logic        LVL_DOM           = 1'b0;
  localparam logic        LVL_REC           = 1'b1;

  // monitor states
  typedef enum logic [1:0] {
    CWPM_IDLE     = 2'b00,
    CWPM_WAIT_REC = 2'b01,
    CWPM_WAIT_DOM = 2'b10,
    CWPM_WOKEN    = 2'b11
  } cwpm_state_t;

  // filtered bus event travelling through the fifo
  typedef struct packed {
    logic dom_start; // filtered dominant begins
    logic dom_end;   // that dominant has ended
  } cwpm_evt_t;
endpackage : cwpm_pkg
